// ==== logic/sbc_pkg.sv ====
// package for the sequential break channel block: channel numbering, sequence modes,
// action codes and the channel capability masks.
// assumes match pulses arrive already synchronous to mclk from the comparators.
package sbc_pkg;

  localparam int NCH = 12;
  localparam int PW  = 4;

  // channel indices, zero based: channel n sits at bit n-1
  localparam int C1  = 0;
  localparam int C2  = 1;
  localparam int C3  = 2;
  localparam int C4  = 3;
  localparam int C5  = 4;
  localparam int C6  = 5;
  localparam int C8  = 7;
  localparam int C9  = 8;
  localparam int C10 = 9;
  localparam int C11 = 10;

  // channels able to trace (5, 6, 8, 9, 12) and the one with break fixed (7)
  localparam logic [NCH-1:0] TRACE_CAP = 12'h9b0;
  localparam logic [NCH-1:0] SYS_CH    = 12'h180;
  localparam logic [NCH-1:0] BRK_ONLY  = 12'h040;

  // prerequisite code: 0 none, 1..12 channel, 13 cpu match flag
  localparam logic [PW-1:0] PRE_NONE = 4'h0;
  localparam logic [PW-1:0] PRE_FLAG = 4'hd;

  // flag action per channel
  localparam logic [1:0] FLG_NONE = 2'h0;
  localparam logic [1:0] FLG_SET  = 2'h1;
  localparam logic [1:0] FLG_CLR  = 2'h2;

  typedef enum logic [3:0] {
    SBC_CPU_OFF, SBC_C2_1, SBC_C4_3, SBC_C6_5, SBC_C11_10,
    SBC_C3_1, SBC_C4_1, SBC_C5_1, SBC_C6_1, SBC_C10_1, SBC_C11_1, SBC_CPU_EXT
  } sbc_cpu_mode_e;

  typedef enum logic [1:0] {
    SBC_SYS_OFF, SBC_S9_8, SBC_S8_9, SBC_SYS_EXT
  } sbc_sys_mode_e;

endpackage

// ==== logic/sbc_chain.sv ====
// one fixed-order sequencer: steps through up to eight channel indices.
// assumes match pulses and the clear are on mclk.
`timescale 1ns/10ps
module sbc_chain (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    clr,
  input  wire logic [sbc_pkg::NCH-1:0] hit,
  input  wire logic [3:0]              len,
  input  wire logic [31:0]             order,
  output logic                         done
);
  logic [3:0] step_r;
  logic [3:0] step_nxt;
  wire  [3:0] cur_ch = order[{step_r[2:0], 2'b00} +: 4];
  wire        cur_hit = hit[cur_ch];
  wire        last    = (step_r == len - 4'h1);

  // progress advances one channel per matching pulse; a mismatch leaves progress alone
  always_comb begin
    step_nxt = step_r;
    if (clr || len == 4'h0)
      step_nxt = 4'h0;
    else if (cur_hit && !last)
      step_nxt = step_r + 4'h1;
  end

  assign done = (len != 4'h0) && cur_hit && last && !clr;

  always_ff @(posedge mclk) begin
    if (rst)
      step_r <= 4'h0;
    else
      step_r <= step_nxt;
  end
endmodule

// ==== logic/sbc_ext.sv ====
// extended-mode sequencer: per channel prerequisite and cpu match flag handling.
// assumes configuration is steady while armed.
`timescale 1ns/10ps
module sbc_ext (
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic                         en,
  input  wire logic                         clr,
  input  wire logic [sbc_pkg::NCH-1:0]      scope,
  input  wire logic [sbc_pkg::NCH-1:0]      hit,
  input  wire logic [sbc_pkg::NCH*4-1:0]    pre_sel,
  input  wire logic [sbc_pkg::NCH*2-1:0]    flg_act,
  output logic [sbc_pkg::NCH-1:0]           fired,
  output logic [sbc_pkg::NCH-1:0]           is_pre,
  output logic                              flag
);
  logic [sbc_pkg::NCH-1:0] seen_r;
  logic                    flag_r;
  logic [sbc_pkg::NCH-1:0] set_v;
  logic [sbc_pkg::NCH-1:0] clr_v;

  genvar g;
  generate
    for (g = 0; g < sbc_pkg::NCH; g++) begin : g_ch
      wire [3:0] p  = pre_sel[g*4 +: 4];
      wire       ok = (p == sbc_pkg::PRE_NONE) ? 1'b1 :
                      (p == sbc_pkg::PRE_FLAG) ? flag_r :
                      (p <= 4'(sbc_pkg::NCH))  ? seen_r[p - 4'h1] : 1'b0;
      assign fired[g] = en && scope[g] && hit[g] && ok;
      assign set_v[g] = fired[g] && flg_act[g*2 +: 2] == sbc_pkg::FLG_SET;
      assign clr_v[g] = fired[g] && flg_act[g*2 +: 2] == sbc_pkg::FLG_CLR;
      assign is_pre[g] = en && scope[g] &&
                         (|{pre_sel[0*4 +: 4] == 4'(g+1), pre_sel[1*4 +: 4] == 4'(g+1),
                            pre_sel[2*4 +: 4] == 4'(g+1), pre_sel[3*4 +: 4] == 4'(g+1),
                            pre_sel[4*4 +: 4] == 4'(g+1), pre_sel[5*4 +: 4] == 4'(g+1),
                            pre_sel[6*4 +: 4] == 4'(g+1), pre_sel[7*4 +: 4] == 4'(g+1),
                            pre_sel[8*4 +: 4] == 4'(g+1), pre_sel[9*4 +: 4] == 4'(g+1),
                            pre_sel[10*4 +: 4] == 4'(g+1), pre_sel[11*4 +: 4] == 4'(g+1)});
    end
  endgenerate

  assign flag = flag_r;

  always_ff @(posedge mclk) begin
    if (rst || clr || !en) begin
      seen_r <= '0;
      flag_r <= 1'b0;
    end else begin
      seen_r <= seen_r | fired;
      if (|set_v)
        flag_r <= 1'b1;
      else if (|clr_v)
        flag_r <= 1'b0;
    end
  end
endmodule

// ==== logic/sbc_top.sv ====
// top of the sequential break channel block: mode decode, fixed chains, extended
// sequencing and per channel actions.
// assumes channel match pulses are one mclk cycle wide and come from same-clock logic;
// configuration inputs are static while armed.
`timescale 1ns/10ps
module sbc_top (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic [sbc_pkg::NCH-1:0]     ch_hit,
  input  wire logic [3:0]                  cpu_mode,
  input  wire logic [1:0]                  sys_mode,
  input  wire logic [sbc_pkg::NCH-1:0]     act_break,
  input  wire logic [sbc_pkg::NCH-1:0]     act_trace,
  input  wire logic [sbc_pkg::NCH-1:0]     act_perf_start,
  input  wire logic [sbc_pkg::NCH-1:0]     act_perf_end,
  input  wire logic [sbc_pkg::NCH*4-1:0]   prerequisite_channel,
  input  wire logic [sbc_pkg::NCH*2-1:0]   flag_action,
  output logic                             brk_req,
  output logic [sbc_pkg::NCH-1:0]          trace_req,
  output logic                             perf_start,
  output logic                             perf_end,
  output logic                             cpu_match_flag
);
  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  sbc_pkg::sbc_cpu_mode_e cmode;
  sbc_pkg::sbc_sys_mode_e smode;
  assign cmode = sbc_pkg::sbc_cpu_mode_e'(cpu_mode);
  assign smode = sbc_pkg::sbc_sys_mode_e'(sys_mode);

  logic [3:0]  clen;
  logic [31:0] cord;
  logic [3:0]  slen;
  logic [31:0] sord;

  // channel orders packed four bits per step, first channel in the low nibble
  always_comb begin
    clen = 4'h0;
    cord = 32'h0;
    case (cmode)
      sbc_pkg::SBC_C2_1:   begin clen = 4'h2; cord = 32'h0000_0001; end
      sbc_pkg::SBC_C4_3:   begin clen = 4'h2; cord = 32'h0000_0023; end
      sbc_pkg::SBC_C6_5:   begin clen = 4'h2; cord = 32'h0000_0045; end
      sbc_pkg::SBC_C11_10: begin clen = 4'h2; cord = 32'h0000_009a; end
      sbc_pkg::SBC_C3_1:   begin clen = 4'h3; cord = 32'h0000_0012; end
      sbc_pkg::SBC_C4_1:   begin clen = 4'h4; cord = 32'h0000_0123; end
      sbc_pkg::SBC_C5_1:   begin clen = 4'h5; cord = 32'h0001_2345 >> 4; end
      sbc_pkg::SBC_C6_1:   begin clen = 4'h6; cord = 32'h0001_2345; end
      sbc_pkg::SBC_C10_1:  begin clen = 4'h7; cord = 32'h0012_3459; end
      sbc_pkg::SBC_C11_1:  begin clen = 4'h8; cord = 32'h0123_459a; end
      default:             begin clen = 4'h0; cord = 32'h0; end
    endcase
  end

  always_comb begin
    slen = 4'h0;
    sord = 32'h0;
    case (smode)
      sbc_pkg::SBC_S9_8: begin slen = 4'h2; sord = 32'h0000_0078; end
      sbc_pkg::SBC_S8_9: begin slen = 4'h2; sord = 32'h0000_0087; end
      default:           begin slen = 4'h0; sord = 32'h0; end
    endcase
  end

  // ------------------------------------------------------------
  // sequencers
  // ------------------------------------------------------------
  logic brk_r;
  wire  cpu_done;
  wire  sys_done;
  wire  cpu_ext = (cmode == sbc_pkg::SBC_CPU_EXT);
  wire  sys_ext = (smode == sbc_pkg::SBC_SYS_EXT);

  sbc_chain u_cpu_chain (
    .mclk  (mclk),
    .rst   (rst),
    .clr   (brk_r),
    .hit   (ch_hit),
    .len   (clen),
    .order (cord),
    .done  (cpu_done)
  );

  sbc_chain u_sys_chain (
    .mclk  (mclk),
    .rst   (rst),
    .clr   (brk_r),
    .hit   (ch_hit),
    .len   (slen),
    .order (sord),
    .done  (sys_done)
  );

  wire [sbc_pkg::NCH-1:0] ext_scope = (cpu_ext ? ~sbc_pkg::SYS_CH : '0) | (sys_ext ? sbc_pkg::SYS_CH : '0);
  wire [sbc_pkg::NCH-1:0] ext_fired;
  wire [sbc_pkg::NCH-1:0] ext_pre;
  wire                    ext_flag;

  sbc_ext u_ext (
    .mclk    (mclk),
    .rst     (rst),
    .en      (cpu_ext || sys_ext),
    .clr     (brk_r),
    .scope   (ext_scope),
    .hit     (ch_hit),
    .pre_sel (prerequisite_channel),
    .flg_act (flag_action),
    .fired   (ext_fired),
    .is_pre  (ext_pre),
    .flag    (ext_flag)
  );

  // ------------------------------------------------------------
  // actions
  // ------------------------------------------------------------
  // channels owned by a fixed chain break only through that chain
  wire [sbc_pkg::NCH-1:0] seq_owned;
  wire [sbc_pkg::NCH-1:0] eff_hit;
  wire [sbc_pkg::NCH-1:0] brk_en;
  genvar g;
  generate
    for (g = 0; g < sbc_pkg::NCH; g++) begin : g_own
      // only steps below the chain length count: unused nibbles read as channel 1
      wire in_c = (clen > 4'h0 && cord[3:0] == 4'(g)) || (clen > 4'h1 && cord[7:4] == 4'(g)) ||
                  (clen > 4'h2 && cord[11:8] == 4'(g)) || (clen > 4'h3 && cord[15:12] == 4'(g)) ||
                  (clen > 4'h4 && cord[19:16] == 4'(g)) || (clen > 4'h5 && cord[23:20] == 4'(g)) ||
                  (clen > 4'h6 && cord[27:24] == 4'(g)) || (clen > 4'h7 && cord[31:28] == 4'(g));
      wire in_s = (slen != 4'h0) && (g == sbc_pkg::C8 || g == sbc_pkg::C9);
      assign seq_owned[g] = in_c || in_s;
    end
  endgenerate

  // in extended scope a channel counts only when fired and not a prerequisite
  assign eff_hit = (ch_hit & ~ext_scope) | (ext_fired & ~ext_pre);
  // break where the channel allows it
  assign brk_en  = (act_break | sbc_pkg::BRK_ONLY) & ~seq_owned;

  wire brk_nxt = !brk_r && ((|(eff_hit & brk_en)) || cpu_done || sys_done);
  wire [sbc_pkg::NCH-1:0] trace_nxt = eff_hit & act_trace & sbc_pkg::TRACE_CAP;
  wire ps_nxt = |(eff_hit & act_perf_start & ~sbc_pkg::BRK_ONLY);
  wire pe_nxt = |(eff_hit & act_perf_end & ~sbc_pkg::BRK_ONLY);

  always_ff @(posedge mclk) begin
    if (rst) begin
      brk_r      <= 1'b0;
      trace_req  <= '0;
      perf_start <= 1'b0;
      perf_end   <= 1'b0;
    end else begin
      brk_r      <= brk_nxt;
      trace_req  <= trace_nxt;
      perf_start <= ps_nxt;
      perf_end   <= pe_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst)
      cpu_match_flag <= 1'b0;
    else
      cpu_match_flag <= ext_flag;
  end

  assign brk_req = brk_r;
endmodule

// ==== dv/sbc_top_assertions.sv ====
// checker for the sequential break block, on its top ports only.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module sbc_top_assertions (
  input wire logic                      mclk,
  input wire logic                      rst,
  input wire logic [sbc_pkg::NCH-1:0]   ch_hit,
  input wire logic [3:0]                cpu_mode,
  input wire logic [1:0]                sys_mode,
  input wire logic [sbc_pkg::NCH-1:0]   act_break,
  input wire logic [sbc_pkg::NCH-1:0]   act_trace,
  input wire logic [sbc_pkg::NCH-1:0]   act_perf_start,
  input wire logic [sbc_pkg::NCH-1:0]   act_perf_end,
  input wire logic [sbc_pkg::NCH*4-1:0] prerequisite_channel,
  input wire logic [sbc_pkg::NCH*2-1:0] flag_action,
  input wire logic                      brk_req,
  input wire logic [sbc_pkg::NCH-1:0]   trace_req,
  input wire logic                      perf_start,
  input wire logic                      perf_end,
  input wire logic                      cpu_match_flag
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // single-hit checks are armed only with both sequencers off
  wire off_w = cpu_mode == 4'h0 && sys_mode == 2'h0;

  chk_brk_single: assert property (brk_req |=> !brk_req)
    else $error("break request held two cycles");
  chk_brk_cause: assert property (brk_req |-> $past(ch_hit) != 12'h000)
    else $error("break request without a hit");
  chk_c21_order: assert property (brk_req && cpu_mode == 4'h1 && sys_mode == 2'h0
    |-> $past(ch_hit[0]) || ($past(ch_hit) & 12'hffc) != 12'h000) else $error("mode 1 break not on channel 1");
  chk_s98_order: assert property (brk_req && sys_mode == 2'h1 && cpu_mode == 4'h0
    |-> $past(ch_hit[7]) || ($past(ch_hit) & 12'he7f) != 12'h000) else $error("sys break not on channel 8");
  chk_ch7_brk: assert property (off_w && !brk_req && ch_hit[6] |=> brk_req)
    else $error("channel 7 did not break");
  chk_trace_fire: assert property (off_w && !brk_req && ch_hit[4] && act_trace[4] |=> trace_req[4])
    else $error("trace pulse missing");
  chk_trace_src: assert property (trace_req != 12'h000
    |-> (trace_req & ~($past(ch_hit & act_trace) & sbc_pkg::TRACE_CAP)) == 12'h000) else $error("stray trace");
  chk_perf_fire: assert property (off_w && !brk_req
    && (ch_hit & act_perf_end & ~sbc_pkg::BRK_ONLY) != 12'h000 |=> perf_end) else $error("perf end missing");
  chk_flag_src: assert property ($rose(cpu_match_flag)
    |-> cpu_mode == 4'hb && ($past(ch_hit) | $past(ch_hit, 2)) != 12'h000) else $error("flag rose unprompted");
  chk_flag_brk: assert property (brk_req && cpu_mode == 4'hb |-> ##[1:3] !cpu_match_flag)
    else $error("flag kept after break");
  cover property (brk_req && cpu_mode == 4'ha);
  cover property (trace_req != 12'h000);
  cover property ($rose(cpu_match_flag));
endmodule

// ==== dv/sbc_cpu_model.sv ====
// stand-in for the monitored cpu and system bus: turns a bench request into a match pulse.
// assumes requests last one mclk cycle.
`timescale 1ns/10ps
module sbc_cpu_model (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    go,
  input  wire logic [3:0]              chan,
  input  wire logic                    brk_req,
  output logic      [sbc_pkg::NCH-1:0] ch_hit,
  output logic      [7:0]              brk_cnt
);
  // ----------------------------------------
  // match pulses and halt count
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    // a match is a pulse, never a level, so one request cannot step a chain twice
    ch_hit  <= (go && !rst) ? 12'h001 << (chan - 4'h1) : 12'h000;
    brk_cnt <= rst ? 8'h00 : brk_cnt + {7'h00, brk_req};
  end
endmodule

// ==== dv/tb_sbc_top.sv ====
// bench for the sequential break block, fed by the cpu stand-in.
// assumes break, trace and perf pulses come one cycle after the hit.
`timescale 1ns/10ps
module tb_sbc_top;
  logic                      mclk = 1'b0, rst = 1'b1, go = 1'b0;
  logic [3:0]                chan = 4'h0, cpu_mode = 4'h0;
  logic [1:0]                sys_mode = 2'h0;
  logic [sbc_pkg::NCH-1:0]   act_break = 12'hfff, act_trace = 12'h000;
  logic [sbc_pkg::NCH-1:0]   act_perf_start = 12'h000, act_perf_end = 12'h000;
  logic [sbc_pkg::NCH*4-1:0] prerequisite_channel = 48'h0;
  logic [sbc_pkg::NCH*2-1:0] flag_action = 24'h0;
  logic [sbc_pkg::NCH-1:0]   ch_hit, trace_req, trc_seen;
  logic                      brk_req, perf_start, perf_end, cpu_match_flag, ps_seen, pe_seen, flg_seen;
  logic [7:0]                brk_cnt;
  int                        err_count = 0, tests_run = 0, cyc = 0;
  // ----------------------------------------
  // rows: mode, sys mode, hits, breaks, hits in order
  // ----------------------------------------
  logic [47:0] rows [18] = '{
    48'h103121100000,
    48'h102012000000,
    48'h202143000000,
    48'h201110000000,
    48'h302165000000,
    48'h4021ba000000,
    48'h4020ab000000,
    48'h503132100000,
    48'h503023100000,
    48'h604143210000,
    48'h705154321000,
    48'h806165432100,
    48'h806065423100,
    48'h9071a6543210,
    48'ha081ba654321,
    48'h012198000000,
    48'h012089000000,
    48'h022189000000
  };
  sbc_top dut (.mclk, .rst, .ch_hit, .cpu_mode, .sys_mode, .act_break, .act_trace, .act_perf_start,
    .act_perf_end, .prerequisite_channel, .flag_action, .brk_req, .trace_req, .perf_start, .perf_end,
    .cpu_match_flag);
  sbc_cpu_model u_cpu (.mclk, .rst, .go, .chan, .brk_req, .ch_hit, .brk_cnt);
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    trc_seen <= rst ? 12'h000 : trc_seen | trace_req;
    ps_seen  <= rst ? 1'b0 : ps_seen | perf_start;
    pe_seen  <= rst ? 1'b0 : pe_seen | perf_end;
    flg_seen <= rst ? 1'b0 : flg_seen | cpu_match_flag;
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    tests_run++;
    if (got !== ex) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic pulse_rst();
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
  endtask
  // hits spaced so none lands in a break cycle
  task automatic run(input logic [31:0] s, input logic [3:0] n);
    for (int i = 0; i < n; i++) begin
      go <= 1'b1;
      chan <= s[31-4*i -: 4];
      @(posedge mclk);
      go <= 1'b0;
      repeat (3) @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk("reset outputs", 16'h0000, {brk_req, perf_start, perf_end, cpu_match_flag, trace_req});
    foreach (rows[i]) begin
      cpu_mode <= rows[i][47:44];
      sys_mode <= rows[i][41:40];
      pulse_rst();
      run(rows[i][31:0], rows[i][39:36]);
      chk("break count", {12'h000, rows[i][35:32]}, {8'h00, brk_cnt});
    end
    cpu_mode <= 4'h0;
    sys_mode <= 2'h0;
    act_break <= 12'h000;
    act_trace <= 12'h011;
    act_perf_start <= 12'h001;
    act_perf_end <= 12'h002;
    pulse_rst();
    run(32'h51270000, 4'h4);
    chk("trace", 16'h0010, {4'h0, trc_seen});
    chk("perf start end", 16'h0003, {14'h0, pe_seen, ps_seen});
    chk("ch7 break", 16'h0001, {8'h00, brk_cnt});
    cpu_mode <= 4'hb;
    act_break <= 12'h001;
    act_trace <= 12'h000;
    act_perf_start <= 12'h000;
    act_perf_end <= 12'h000;
    prerequisite_channel <= 48'h000000000d02;
    flag_action <= 24'h000240;
    pulse_rst();
    run(32'h13453000, 4'h5);
    chk("gated break", 16'h0000, {8'h00, brk_cnt});
    chk("flag seen", 16'h0001, {15'h0, flg_seen});
    run(32'h43121000, 4'h5);
    chk("ext break", 16'h0001, {8'h00, brk_cnt});
    chk("flag after break", 16'h0000, {15'h0, cpu_match_flag});
    cpu_mode <= 4'h0;
    sys_mode <= 2'h3;
    act_break <= 12'h080;
    prerequisite_channel <= 48'h000090000000;
    flag_action <= 24'h000000;
    pulse_rst();
    run(32'h89800000, 4'h3);
    chk("sys ext break", 16'h0001, {8'h00, brk_cnt});
    conclude();
  end
endmodule
bind sbc_top sbc_top_assertions u_chk (.mclk, .rst, .ch_hit, .cpu_mode, .sys_mode, .act_break, .act_trace,
  .act_perf_start, .act_perf_end, .prerequisite_channel, .flag_action, .brk_req, .trace_req, .perf_start,
  .perf_end, .cpu_match_flag);
